// ===== sim/pbs_module_model.sv
`timescale 1ns/1ns
module pbs_module_model #(
   parameter int CYC_PER_MS = 4
) (
   input  wire logic       mclk,
   input  wire logic       module_input_power_enable,
   input  wire logic       pmic_enable,
   input  wire logic       buffered_button_out_n_o,
   input  wire logic       buffered_button_out_n_oe,
   input  wire logic [7:0] grant_ms,
   input  wire logic       grant_drop,
   input  wire logic       reset_hold,
   input  wire logic       overtemp_req,
   output logic            carrier_power_grant,
   output logic            system_reset_line_n,
   output logic            overtemp_off_request_n,
   output logic            buffered_button_out_n_i
);
   int cnt = 0;

   // grant only once both enables have stood for the grant delay
   always @(posedge mclk) begin
      if (!(pmic_enable === 1'b1 && module_input_power_enable === 1'b1)) begin
         cnt <= 0;
         carrier_power_grant <= 1'b0;
      end else if (cnt < int'(grant_ms) * CYC_PER_MS) begin
         cnt <= cnt + 1;
      end else begin
         carrier_power_grant <= !grant_drop;
      end
   end

   // reset line held by the module until carrier power is granted
   assign system_reset_line_n    = carrier_power_grant && !reset_hold;
   assign overtemp_off_request_n = !overtemp_req;
   // pin pulled up on the module, pulled low while the supervisor sinks it
   assign buffered_button_out_n_i = (buffered_button_out_n_oe === 1'b1) ? buffered_button_out_n_o : 1'b1;
endmodule : pbs_module_model

// ===== sim/tb_power_button_supervisor.sv
`timescale 1ns/1ns
module tb_power_button_supervisor;
   localparam int C    = 4;
   localparam int HOLD = 30;
   localparam int OFF2 = 15;
   localparam int DEB  = pbs_pkg::T_DEBOUNCE_MS;
   localparam int VON  = pbs_pkg::T_VPWR_ON_MS;
   localparam int MPO  = pbs_pkg::T_MPO_MS;
   localparam int OFF1 = pbs_pkg::T_VPWR_OFF1_MS;

   logic       mclk, sys_rst, button_n, main_power_ok, board_select_strap;
   logic       grant_drop, reset_hold, overtemp_req;
   logic [7:0] grant_ms;
   logic       carrier_power_grant, system_reset_line_n, overtemp_off_request_n, pin_n;
   logic       vin, pmic, od_o, od_oe, pg, board_select;
   logic [3:0] outs;
   logic [3:0] prev = 4'h0;
   int         cyc = 0;
   int         n_fail = 0;
   int         checked = 0;
   int         t0, t1, w;
   int         t_up[4];
   int         t_dn[4];

   assign outs = {pg, od_oe, pmic, vin};

   pbs_supervisor #(.CYC_PER_MS(C), .FORCE_HOLD_MS(HOLD), .MPO_OFF2_MS(OFF2)) pbs_supervisor_i (
      .mclk(mclk), .sys_rst(sys_rst), .button_n(button_n), .main_power_ok(main_power_ok),
      .carrier_power_grant(carrier_power_grant), .system_reset_line_n(system_reset_line_n),
      .overtemp_off_request_n(overtemp_off_request_n), .board_select_strap(board_select_strap),
      .module_input_power_enable(vin), .pmic_enable(pmic), .buffered_button_out_n_i(pin_n),
      .buffered_button_out_n_o(od_o), .buffered_button_out_n_oe(od_oe), .power_good_check(pg),
      .board_select(board_select));

   pbs_module_model #(.CYC_PER_MS(C)) pbs_module_model_i (
      .mclk(mclk), .module_input_power_enable(vin), .pmic_enable(pmic), .buffered_button_out_n_o(od_o),
      .buffered_button_out_n_oe(od_oe), .grant_ms(grant_ms), .grant_drop(grant_drop),
      .reset_hold(reset_hold), .overtemp_req(overtemp_req), .carrier_power_grant(carrier_power_grant),
      .system_reset_line_n(system_reset_line_n), .overtemp_off_request_n(overtemp_off_request_n),
      .buffered_button_out_n_i(pin_n));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // edge time stamps of the outputs, in cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      prev <= outs;
      for (int k = 0; k < 4; k++) begin
         if (outs[k] === 1'b1 && prev[k] !== 1'b1) t_up[k] = cyc;
         if (outs[k] === 1'b0 && prev[k] === 1'b1) t_dn[k] = cyc;
      end
   end

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic chk_ms(input string what, input int got, input int lo, input int hi);
      checked++;
      if (got < lo * C - 2 || got > hi * C + 3) begin
         n_fail++;
         $display("unexpected at %0t: %s took %0d cycles, not %0d..%0d ms", $time, what, got, lo, hi);
      end
   endtask : chk_ms

   task automatic chk_bit(input string what, input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s is %b", $time, what, got);
      end
   endtask : chk_bit

   task automatic ticks(input int ms);
      repeat (ms * C) @(posedge mclk);
   endtask : ticks

   task automatic wait_for(input int k, input logic v, input int ms);
      int n;
      n = 0;
      while (outs[k] !== v && n < ms * C) begin
         @(posedge mclk);
         n++;
      end
      #1;
      checked++;
      if (outs[k] !== v) begin
         n_fail++;
         $display("unexpected at %0t: output %0d never reached %b", $time, k, v);
      end
   endtask : wait_for

   task automatic press(input int ms);
      @(posedge mclk) button_n <= 1'b0;
      t0 = cyc;
      ticks(ms);
      button_n <= 1'b1;
   endtask : press

   task automatic btn_on(input int wid, input logic ac, input int gm);
      @(posedge mclk) grant_ms <= 8'(gm);
      @(posedge mclk) button_n <= 1'b0;
      t0 = cyc;
      ticks(5);
      main_power_ok <= ac;
      ticks(wid - 5);
      button_n <= 1'b1;
      wait_for(0, 1'b1, 2 * DEB + 5);
      chk_ms("press to input power", t_up[0] - t0, DEB + VON - 2, DEB + VON);
      chk_ms("press to button out", t_up[2] - t0, DEB + pbs_pkg::T_PB_OUT_MS - 2, DEB + pbs_pkg::T_PB_OUT_MS);
      wait_for(1, 1'b1, MPO + 5);
      chk_ms("input power to pmic", t_up[1] - t_up[0], MPO, MPO);
      chk_ms("button out width", t_dn[2] - t_up[2], wid - 1, wid + 1);
      wait_for(3, 1'b1, gm + 5);
      chk_ms("pmic to power good", t_up[3] - t_up[1], gm, gm);
   endtask : btn_on

   task automatic off_tail(input string what);
      wait_for(1, 1'b0, OFF2 + 5);
      chk_ms("rail off to pmic off", t_dn[1] - t_dn[0], OFF2, OFF2);
      ticks(2 * DEB + 20);
      chk_bit("input power after shutdown", vin, 1'b0);
      $display("test %s done", what);
   endtask : off_tail

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      void'($urandom(32'h7361));
      sys_rst = 1'b1;
      button_n = 1'b1;
      main_power_ok = 1'b0;
      board_select_strap = $urandom_range(1, 0);
      grant_ms = 8'h0A;
      grant_drop = 1'b0;
      reset_hold = 1'b0;
      overtemp_req = 1'b0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk_bit("outputs after reset", |{vin, pmic, od_o, od_oe, pg}, 1'b0);
      chk_bit("strap capture", board_select, board_select_strap);
      $display("test reset done");

      press($urandom_range(12, 2));
      ticks(3 * DEB);
      chk_bit("input power after glitch", vin, 1'b0);
      chk_bit("button out after glitch", od_oe, 1'b0);
      $display("test glitch done");

      btn_on(25 + $urandom_range(15, 0), 1'b1, 10);
      $display("test button power on done");

      @(posedge mclk) reset_hold <= 1'b1;
      ticks(1);
      chk_bit("power good with reset low", pg, 1'b0);
      chk_bit("input power with reset low", vin, 1'b1);
      reset_hold <= 1'b0;
      ticks(1);
      chk_bit("power good after reset high", pg, 1'b1);
      $display("test reset mask done");

      @(posedge mclk) button_n <= 1'b0;
      t0 = cyc;
      wait_for(0, 1'b0, DEB + HOLD + OFF1 + 5);
      chk_ms("hold to input power off", t_dn[0] - t0, DEB + HOLD + OFF1 - 1, DEB + HOLD + OFF1);
      chk_bit("button relayed in hold", od_oe, 1'b1);
      chk_bit("button pin in hold", pin_n, 1'b0);
      @(posedge mclk) button_n <= 1'b1;
      off_tail("long hold");

      @(posedge mclk) main_power_ok <= 1'b0;
      ticks(DEB + 10);
      @(posedge mclk) main_power_ok <= 1'b1;
      t1 = cyc;
      ticks(10);
      w = 30;
      press(w);
      wait_for(0, 1'b1, 2 * DEB);
      chk_ms("supply to input power", t_up[0] - t1, DEB + pbs_pkg::T_VPWR_ON_AC_MS - 2,
             DEB + pbs_pkg::T_VPWR_ON_AC_MS);
      wait_for(1, 1'b1, MPO + 5);
      chk_ms("press to button out in auto", t_up[2] - t0, 2 * DEB - 2, 2 * DEB);
      chk_ms("auto input power to pmic", t_up[1] - t_up[0], pbs_pkg::T_MPO_AC_MS, pbs_pkg::T_MPO_AC_MS);
      wait_for(3, 1'b1, 15);
      chk_bit("auto power good", pg, 1'b1);
      $display("test auto power on done");

      @(posedge mclk) overtemp_req <= 1'b1;
      t0 = cyc;
      wait_for(0, 1'b0, OFF1 + 5);
      chk_ms("overtemp to input power off", t_dn[0] - t0, OFF1, OFF1);
      @(posedge mclk) overtemp_req <= 1'b0;
      off_tail("overtemp");

      @(posedge mclk) main_power_ok <= 1'b0;
      ticks(DEB + 10);
      btn_on(30, 1'b0, 30);
      @(posedge mclk) grant_drop <= 1'b1;
      t0 = cyc;
      wait_for(0, 1'b0, OFF1 + 5);
      chk_ms("grant loss to input power off", t_dn[0] - t0, OFF1, OFF1);
      @(posedge mclk) grant_drop <= 1'b0;
      off_tail("grant loss");
      close_out();
   end
endmodule : tb_power_button_supervisor

// ===== verilog/pbs_debounce.sv
`timescale 1ns/1ns
module pbs_debounce #(
   parameter int   DEB_MS = pbs_pkg::T_DEBOUNCE_MS,
   parameter logic INIT   = pbs_pkg::DEB_INIT_LEVEL
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic raw,
   pbs_tick_if.snk   tk,
   output logic      level_q
);
   localparam int CW = $clog2(DEB_MS + 1);

   logic [CW-1:0] cnt_q;
   logic          done;

   // level follows raw only after DEB_MS whole ticks of disagreement
   assign done = (raw != level_q) && tk.tick && (cnt_q == CW'(DEB_MS - 1));

   always_ff @(posedge mclk) begin
      if (sys_rst || raw == level_q || done) begin
         cnt_q <= '0;
      end else if (tk.tick) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level_q <= INIT;
      end else if (done) begin
         level_q <= raw;
      end
   end

   chk_level_stable: assert property (@(posedge mclk) disable iff (sys_rst)
      $changed(level_q) |-> $past(tk.tick) && $past(raw) == level_q && $past(cnt_q) == CW'(DEB_MS - 1))
      else $error("debounced level changed without a full stable interval");

endmodule : pbs_debounce

// ===== verilog/pbs_pkg.sv
package pbs_pkg;

   // clock and time units
   localparam int CLK_PERIOD_NS = 8;
   localparam int NS_PER_MS     = 1000000;
   localparam int MS_PER_S      = 1000;
   localparam int CYC_PER_MS    = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // button and supply timing, in ms unless marked _S
   localparam int T_DEBOUNCE_MS   = 20;
   localparam int T_PB_OUT_MS     = 20;
   localparam int T_VPWR_ON_MS    = 20;
   localparam int T_VPWR_ON_AC_MS = 20;
   localparam int T_MPO_MS        = 80;
   localparam int T_MPO_AC_MS     = 80;
   localparam int T_FORCE_HOLD_S  = 10;
   localparam int T_FORCE_HOLD_MS = T_FORCE_HOLD_S * MS_PER_S;
   localparam int T_VPWR_OFF1_MS  = 10;
   localparam int T_MPO_OFF2_S    = 10;
   localparam int T_MPO_OFF2_MS   = T_MPO_OFF2_S * MS_PER_S;

   // millisecond counter width, holds the longest delay
   localparam int TMR_W = 14;

   // reset levels of the pin-side state
   localparam logic OUT_OFF_RST     = 1'b0;
   localparam logic LINE_HIGH_RST   = 1'b1;
   localparam logic DEB_INIT_LEVEL  = 1'b0;

   typedef enum logic [2:0] {
      S_OFF,
      S_BTN_VIN,
      S_AC_VIN,
      S_MPO,
      S_PG,
      S_ON,
      S_OFF_RAIL,
      S_OFF_PMIC
   } pbs_state_t;

endpackage : pbs_pkg

// ===== verilog/pbs_supervisor.sv
`timescale 1ns/1ns
module pbs_supervisor #(
   parameter int CYC_PER_MS    = pbs_pkg::CYC_PER_MS,
   parameter int FORCE_HOLD_MS = pbs_pkg::T_FORCE_HOLD_MS,
   parameter int MPO_OFF2_MS   = pbs_pkg::T_MPO_OFF2_MS,
   parameter int TMR_W         = pbs_pkg::TMR_W
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic button_n,
   input  wire logic main_power_ok,
   input  wire logic carrier_power_grant,
   input  wire logic system_reset_line_n,
   input  wire logic overtemp_off_request_n,
   input  wire logic board_select_strap,
   output logic      module_input_power_enable,
   output logic      pmic_enable,
   input  wire logic buffered_button_out_n_i,
   output logic      buffered_button_out_n_o,
   output logic      buffered_button_out_n_oe,
   output logic      power_good_check,
   output logic      board_select
);

   pbs_tick_if tk_if ();

   pbs_pkg::pbs_state_t state_q;
   pbs_pkg::pbs_state_t state_d;

   logic             ms_tick;
   logic             btn_press_raw;
   logic             btn_lvl;
   logic             ac_lvl;
   logic             btn_prev_q;
   logic             ac_prev_q;
   logic             rstl_prev_q;
   logic             ot_prev_q;
   logic             btn_rise;
   logic             btn_edge;
   logic             ac_rise;
   logic             rst_edge;
   logic             ot_fall;
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] hold_q;
   logic             hold_fire;
   logic             src_btn_q;
   logic             vin_q;
   logic             pmic_q;
   logic             pg_q;
   logic             pb_busy_q;
   logic             pb_pend_q;
   logic [TMR_W-1:0] pb_cnt_q;
   logic             pb_fire;
   logic             pb_out_q;
   logic             strap_done_q;
   logic             board_sel_q;

   // true on the tick that ends a delay of lim_ms whole ticks
   function automatic logic expired(input logic tk, input logic [TMR_W-1:0] cnt, input int lim_ms);
      if (lim_ms == 0) begin
         return 1'b1;
      end
      return tk && (cnt == TMR_W'(lim_ms - 1));
   endfunction : expired

   pbs_tick_gen #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tick (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .tk      (tk_if.src)
   );

   assign ms_tick       = tk_if.tick;
   assign btn_press_raw = ~button_n;

   pbs_debounce #(
      .DEB_MS (pbs_pkg::T_DEBOUNCE_MS),
      .INIT   (pbs_pkg::DEB_INIT_LEVEL)
   ) u_deb_btn (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .raw     (btn_press_raw),
      .tk      (tk_if.snk),
      .level_q (btn_lvl)
   );

   pbs_debounce #(
      .DEB_MS (pbs_pkg::T_DEBOUNCE_MS),
      .INIT   (pbs_pkg::DEB_INIT_LEVEL)
   ) u_deb_ac (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .raw     (main_power_ok),
      .tk      (tk_if.snk),
      .level_q (ac_lvl)
   );

   // edge detection on debounced and module-side lines
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         btn_prev_q  <= pbs_pkg::DEB_INIT_LEVEL;
         ac_prev_q   <= pbs_pkg::DEB_INIT_LEVEL;
         rstl_prev_q <= pbs_pkg::LINE_HIGH_RST;
         ot_prev_q   <= pbs_pkg::LINE_HIGH_RST;
      end else begin
         btn_prev_q  <= btn_lvl;
         ac_prev_q   <= ac_lvl;
         rstl_prev_q <= system_reset_line_n;
         ot_prev_q   <= overtemp_off_request_n;
      end
   end

   assign btn_rise = btn_lvl & ~btn_prev_q;
   assign btn_edge = btn_lvl ^ btn_prev_q;
   assign ac_rise  = ac_lvl & ~ac_prev_q;
   assign rst_edge = rstl_prev_q ^ system_reset_line_n;
   assign ot_fall  = ot_prev_q & ~overtemp_off_request_n;

   assign hold_fire = btn_lvl && expired(ms_tick, hold_q, FORCE_HOLD_MS);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pbs_pkg::S_OFF: begin
            if (btn_rise) begin
               state_d = pbs_pkg::S_BTN_VIN;
            end else if (ac_rise) begin
               state_d = pbs_pkg::S_AC_VIN;
            end
         end
         pbs_pkg::S_BTN_VIN: begin
            // supply-ok is not looked at here
            if (expired(ms_tick, tmr_q, pbs_pkg::T_VPWR_ON_MS)) begin
               state_d = pbs_pkg::S_MPO;
            end
         end
         pbs_pkg::S_AC_VIN: begin
            // button is not looked at until power good
            if (expired(ms_tick, tmr_q, pbs_pkg::T_VPWR_ON_AC_MS)) begin
               state_d = pbs_pkg::S_MPO;
            end
         end
         pbs_pkg::S_MPO: begin
            if (ot_fall) begin
               state_d = pbs_pkg::S_OFF_RAIL;
            end else if (expired(ms_tick, tmr_q, src_btn_q ? pbs_pkg::T_MPO_MS : pbs_pkg::T_MPO_AC_MS)) begin
               state_d = pbs_pkg::S_PG;
            end
         end
         pbs_pkg::S_PG: begin
            if (ot_fall) begin
               state_d = pbs_pkg::S_OFF_RAIL;
            end else if (carrier_power_grant && system_reset_line_n && !rst_edge) begin
               state_d = pbs_pkg::S_ON;
            end
         end
         pbs_pkg::S_ON: begin
            if (ot_fall || hold_fire || !carrier_power_grant) begin
               state_d = pbs_pkg::S_OFF_RAIL;
            end
         end
         pbs_pkg::S_OFF_RAIL: begin
            if (expired(ms_tick, tmr_q, pbs_pkg::T_VPWR_OFF1_MS)) begin
               state_d = pbs_pkg::S_OFF_PMIC;
            end
         end
         pbs_pkg::S_OFF_PMIC: begin
            if (expired(ms_tick, tmr_q, MPO_OFF2_MS)) begin
               state_d = pbs_pkg::S_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= pbs_pkg::S_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // per-state millisecond timer, restarts on every state change
   always_ff @(posedge mclk) begin
      if (sys_rst || state_d != state_q) begin
         tmr_q <= '0;
      end else if (ms_tick) begin
         tmr_q <= tmr_q + TMR_W'(1);
      end
   end

   // long-hold counter only runs in S_ON while the debounced button is held, even with power good masked
   always_ff @(posedge mclk) begin
      if (sys_rst || state_q != pbs_pkg::S_ON || !btn_lvl || hold_fire) begin
         hold_q <= '0;
      end else if (ms_tick) begin
         hold_q <= hold_q + TMR_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         src_btn_q <= pbs_pkg::OUT_OFF_RST;
      end else if (state_d == pbs_pkg::S_BTN_VIN) begin
         src_btn_q <= 1'b1;
      end else if (state_d == pbs_pkg::S_AC_VIN) begin
         src_btn_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         vin_q <= pbs_pkg::OUT_OFF_RST;
      end else if (state_q != pbs_pkg::S_MPO && state_d == pbs_pkg::S_MPO) begin
         vin_q <= 1'b1;
      end else if (state_q == pbs_pkg::S_OFF_RAIL && state_d == pbs_pkg::S_OFF_PMIC) begin
         vin_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pmic_q <= pbs_pkg::OUT_OFF_RST;
      end else if (state_q == pbs_pkg::S_MPO && state_d == pbs_pkg::S_PG) begin
         pmic_q <= 1'b1;
      end else if (state_d == pbs_pkg::S_OFF) begin
         pmic_q <= 1'b0;
      end
   end

   // power good is masked while the system reset line is low
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pg_q <= pbs_pkg::OUT_OFF_RST;
      end else begin
         pg_q <= (state_d == pbs_pkg::S_ON) && system_reset_line_n && !rst_edge;
      end
   end

   // buffered button: each debounced edge replayed T_PB_OUT_MS later
   assign pb_fire = pb_busy_q && expired(ms_tick, pb_cnt_q, pbs_pkg::T_PB_OUT_MS);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pb_busy_q <= 1'b0;
         pb_pend_q <= pbs_pkg::DEB_INIT_LEVEL;
         pb_cnt_q  <= '0;
      end else if (btn_edge) begin
         pb_busy_q <= 1'b1;
         pb_pend_q <= btn_lvl;
         pb_cnt_q  <= '0;
      end else if (pb_fire) begin
         pb_busy_q <= 1'b0;
      end else if (pb_busy_q && ms_tick) begin
         pb_cnt_q <= pb_cnt_q + TMR_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pb_out_q <= pbs_pkg::OUT_OFF_RST;
      end else if (pb_fire) begin
         pb_out_q <= pb_pend_q;
      end
   end

   // strap caught once, the first cycle after reset release
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         strap_done_q <= 1'b0;
         board_sel_q  <= pbs_pkg::OUT_OFF_RST;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         board_sel_q  <= board_select_strap;
      end
   end

   assign module_input_power_enable = vin_q;
   assign pmic_enable               = pmic_q;
   assign buffered_button_out_n_o   = 1'b0;
   assign buffered_button_out_n_oe  = pb_out_q;
   assign power_good_check          = pg_q;
   assign board_select              = board_sel_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   chk_off_wait: assert property (
      state_q == pbs_pkg::S_OFF && !btn_rise && !ac_rise |=> state_q == pbs_pkg::S_OFF && !vin_q && !pmic_q)
      else $error("left off state without a debounced trigger");

   chk_vin_btn_delay: assert property (
      state_q == pbs_pkg::S_BTN_VIN && ms_tick && tmr_q == TMR_W'(pbs_pkg::T_VPWR_ON_MS - 1)
      |=> vin_q && !pmic_q && state_q == pbs_pkg::S_MPO)
      else $error("input power not enabled at button delay end");

   chk_vin_ac_delay: assert property (
      state_q == pbs_pkg::S_AC_VIN && ms_tick && tmr_q == TMR_W'(pbs_pkg::T_VPWR_ON_AC_MS - 1)
      |=> vin_q && state_q == pbs_pkg::S_MPO)
      else $error("input power not enabled at supply delay end");

   chk_pmic_delay: assert property (
      $rose(pmic_q) |-> vin_q && $past(state_q) == pbs_pkg::S_MPO && $past(ms_tick)
      && $past(tmr_q) == TMR_W'((src_btn_q ? pbs_pkg::T_MPO_MS : pbs_pkg::T_MPO_AC_MS) - 1))
      else $error("pmic enable rose at wrong time");

   chk_ac_ignored: assert property (
      state_q == pbs_pkg::S_BTN_VIN && ac_rise |=> state_q inside {pbs_pkg::S_BTN_VIN, pbs_pkg::S_MPO})
      else $error("supply-ok disturbed button sequence");

   chk_btn_ignored: assert property (
      state_q inside {pbs_pkg::S_AC_VIN, pbs_pkg::S_MPO, pbs_pkg::S_PG}
      |-> hold_q == '0 ##1 src_btn_q == $past(src_btn_q))
      else $error("button acted before power good");

   chk_force_hold: assert property (
      state_q == pbs_pkg::S_ON && btn_lvl && ms_tick && hold_q == TMR_W'(FORCE_HOLD_MS - 1)
      |=> state_q == pbs_pkg::S_OFF_RAIL && vin_q && pmic_q)
      else $error("long hold did not force shutdown");

   chk_rail_off: assert property (
      state_q == pbs_pkg::S_OFF_RAIL && ms_tick && tmr_q == TMR_W'(pbs_pkg::T_VPWR_OFF1_MS - 1)
      |=> !vin_q && state_q == pbs_pkg::S_OFF_PMIC)
      else $error("input power not removed on time");

   chk_pmic_off: assert property (
      $fell(pmic_q) |-> $past(state_q) == pbs_pkg::S_OFF_PMIC && $past(tmr_q) == TMR_W'(MPO_OFF2_MS - 1) && !vin_q)
      else $error("pmic enable dropped at wrong time");

   chk_ot_shutdown: assert property (
      ot_fall && state_q inside {pbs_pkg::S_MPO, pbs_pkg::S_PG, pbs_pkg::S_ON} |=> state_q == pbs_pkg::S_OFF_RAIL)
      else $error("overtemp request did not start shutdown");

   chk_pg_mask: assert property (
      pg_q |-> $past(system_reset_line_n) && $past(carrier_power_grant) && state_q == pbs_pkg::S_ON)
      else $error("power good without grant or reset release");

   chk_grant_loop: assert property (
      state_q == pbs_pkg::S_ON && !carrier_power_grant |=> state_q == pbs_pkg::S_OFF_RAIL ##1 !pg_q)
      else $error("grant loss not acted on");

   chk_od_drive: assert property (
      !buffered_button_out_n_o && (!$changed(buffered_button_out_n_oe) || $past(pb_fire)))
      else $error("open-drain output drove high or moved outside a replay");

   chk_pb_follow: assert property (
      pb_fire && !btn_edge |=> pb_out_q == $past(pb_pend_q) && !pb_busy_q)
      else $error("buffered button not replayed");

   cov_btn_on: cover property (src_btn_q && $rose(pg_q));
   cov_ac_on: cover property (!src_btn_q && $rose(pg_q));
   cov_hold_off: cover property (hold_fire ##1 state_q == pbs_pkg::S_OFF_RAIL);
   cov_ot_off: cover property (ot_fall && state_q == pbs_pkg::S_ON);
   cov_pin_low: cover property (buffered_button_out_n_oe && !buffered_button_out_n_i);

endmodule : pbs_supervisor

// ===== verilog/pbs_tick_gen.sv
`timescale 1ns/1ns
module pbs_tick_gen #(
   parameter int CYC_PER_MS = pbs_pkg::CYC_PER_MS
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   pbs_tick_if.src   tk
);
   localparam int CW = $clog2(CYC_PER_MS + 1);

   logic [CW-1:0] div_q;
   logic          tick_q;

   // free-running millisecond timebase, one-cycle tick per ms
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == CW'(CYC_PER_MS - 1)) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + CW'(1);
         tick_q <= 1'b0;
      end
   end

   assign tk.tick = tick_q;

endmodule : pbs_tick_gen

// ===== verilog/pbs_tick_if.sv
`timescale 1ns/1ns
interface pbs_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface : pbs_tick_if
